// *** src/sae_map.svh ***
`ifndef SAE_MAP_SVH
`define SAE_MAP_SVH

// Direct special function range
`define SAE_SFR_BIT        7
// Offset within the direct range
`define SAE_OFF_MSB        6
`define SAE_OFF_RST        7'h00
// System control zero register and its map-select bit
`define SAE_SYSTEM_CONTROL_ZERO_ADDR   8'h8F
`define SAE_SYSTEM_CONTROL_ZERO_RST    8'h00
`define SAE_MAP_BIT        0
// Page register layout: page, slot number, operation
`define SAE_PG_MSB         2
`define SAE_SLOT_LSB       4
`define SAE_SLOT_MSB       5
`define SAE_OP_LSB         6
`define SAE_OP_MSB         7
`define SAE_OP_SAVE        2'h2
`define SAE_OP_RESTORE     2'h3
`define SAE_PAGE_RST       3'h0
// Page register address and paged window of each module
`define SAE_PORT_PADDR     8'hB2
`define SAE_PORT_LO        8'hB0
`define SAE_PORT_HI        8'hB3
`define SAE_ADC_PADDR      8'hD1
`define SAE_ADC_LO         8'hCA
`define SAE_ADC_HI         8'hD3
`define SAE_CCU_PADDR      8'hA3
`define SAE_CCU_LO         8'h9A
`define SAE_CCU_HI         8'hA7
`define SAE_SCU_PADDR      8'hBF
`define SAE_SCU_LO         8'hB4
`define SAE_SCU_HI         8'hBF
`define SAE_ZERO8          8'h00

`endif

// *** src/sae_pkg.sv ***
package sae_pkg;

    typedef enum logic [2:0] {
        SAE_MOD_PORT,
        SAE_MOD_ADC,
        SAE_MOD_CCU,
        SAE_MOD_SCU,
        SAE_MOD_NONE
    } sae_mod_t;

    typedef logic [2:0] sae_page_t;

endpackage

// *** src/sae_page_if.sv ***
`timescale 1ns/10ps
interface sae_page_if #(
    parameter int PW = 3
);
    logic          wr;
    logic [7:0]    wdata;
    logic [PW-1:0] page;

    modport ctl  (output wr, output wdata, input page);
    modport unit (input wr, input wdata, output page);
endinterface

// *** src/sae_page_unit.sv ***
`timescale 1ns/10ps
`include "sae_map.svh"
module sae_page_unit #(
    parameter int PW    = 3,
    parameter int SLOTS = 4
) (
    // Clock, reset and enable
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic ce,
    // Page register access
    sae_page_if.unit  pif
);

    logic [PW-1:0] page_reg;
    logic [PW-1:0] slot_reg [SLOTS];
    logic [1:0]    op;
    logic [1:0]    slot;

    assign op   = pif.wdata[`SAE_OP_MSB:`SAE_OP_LSB];
    assign slot = pif.wdata[`SAE_SLOT_MSB:`SAE_SLOT_LSB];

    // Restore ignores the written page value
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            page_reg <= PW'(`SAE_PAGE_RST);
        else if (ce && pif.wr)
        begin
            if (op == `SAE_OP_RESTORE)
                page_reg <= slot_reg[slot];
            else
                page_reg <= pif.wdata[PW-1:0];
        end
    end

    // Save keeps the old page, so no read is ever needed first
    generate
        for (genvar s = 0; s < SLOTS; s++)
        begin : g_slot
            always_ff @(posedge ref_clk or negedge resetn)
            begin
                if (!resetn)
                    slot_reg[s] <= PW'(`SAE_PAGE_RST);
                else if (ce && pif.wr && op == `SAE_OP_SAVE
                         && slot == 2'(s))
                    slot_reg[s] <= page_reg;
            end
        end
    endgenerate

    assign pif.page = page_reg;

endmodule // sae_page_unit

// *** src/sae_top.sv ***
`timescale 1ns/10ps
`include "sae_map.svh"
module sae_top #(
    parameter int NMOD  = 4,
    parameter int PW    = 3,
    parameter int SLOTS = 4
) (
    // Clock, reset, enable
    input  wire logic              ref_clk,
    input  wire logic              resetn,
    input  wire logic              ce,
    // CPU special function register access
    input  wire logic [7:0]        sfr_addr,
    input  wire logic              sfr_wr,
    input  wire logic              sfr_rd,
    input  wire logic [7:0]        sfr_wdata,
    output logic      [7:0]        sfr_rdata,
    output logic                   own_hit,
    // Map state
    output logic                   map_select_bit,
    // Decoded target towards the peripherals
    output logic                   dec_valid,
    output logic                   dec_write,
    output logic                   dec_mapped,
    output sae_pkg::sae_mod_t      dec_mod,
    output logic      [PW-1:0]     dec_page,
    output logic      [6:0]        dec_offset,
    output logic      [7:0]        dec_wdata
);

    // Page register address and paged window of each module
    localparam logic [7:0] PADDR [NMOD] = '{`SAE_PORT_PADDR,
        `SAE_ADC_PADDR, `SAE_CCU_PADDR, `SAE_SCU_PADDR};
    localparam logic [7:0] WLO [NMOD] = '{`SAE_PORT_LO,
        `SAE_ADC_LO, `SAE_CCU_LO, `SAE_SCU_LO};
    localparam logic [7:0] WHI [NMOD] = '{`SAE_PORT_HI,
        `SAE_ADC_HI, `SAE_CCU_HI, `SAE_SCU_HI};

    // Registered state
    logic [7:0]        system_control_zero_reg;
    logic [7:0]        rdata_reg;
    logic              own_hit_reg;
    logic              dvalid_reg;
    logic              dwrite_reg;
    logic              dmapped_reg;
    sae_pkg::sae_mod_t dmod_reg;
    logic [PW-1:0]     dpage_reg;
    logic [6:0]        doff_reg;
    logic [7:0]        dwdata_reg;

    // Decode terms
    logic              in_sfr;
    logic              mapped;
    logic              sys_hit;
    logic [NMOD-1:0]   pg_hit;
    logic [NMOD-1:0]   win_hit;
    logic [PW-1:0]     pages [NMOD];
    logic              own_any;
    logic              acc_any;
    logic              take_ext;
    logic [7:0]        rd_next;
    sae_pkg::sae_mod_t mod_next;
    logic [PW-1:0]     page_next;

    sae_page_if #(.PW(PW)) pif [NMOD] ();

    assign in_sfr  = sfr_addr[`SAE_SFR_BIT];
    assign mapped  = system_control_zero_reg[`SAE_MAP_BIT];
    // Reachable from both portions so software can always leave mapping
    assign sys_hit = in_sfr && sfr_addr == `SAE_SYSTEM_CONTROL_ZERO_ADDR;

    // Map-select only changes on a CPU write
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            system_control_zero_reg <= `SAE_SYSTEM_CONTROL_ZERO_RST;
        else if (ce && sfr_wr && sys_hit)
            system_control_zero_reg <= sfr_wdata;
    end

    // One page unit per paged module, standard portion only
    generate
        for (genvar i = 0; i < NMOD; i++)
        begin : g_mod
            assign pg_hit[i]  = in_sfr && !mapped && !sys_hit
                                && sfr_addr == PADDR[i];
            assign win_hit[i] = in_sfr && !mapped && !pg_hit[i]
                                && sfr_addr >= WLO[i]
                                && sfr_addr <= WHI[i];
            assign pif[i].wr    = sfr_wr && pg_hit[i];
            assign pif[i].wdata = sfr_wdata;
            assign pages[i]     = pif[i].page;

            sae_page_unit #(
                .PW    (PW),
                .SLOTS (SLOTS)
            ) u_page (
                .ref_clk (ref_clk),
                .resetn  (resetn),
                .ce      (ce),
                .pif     (pif[i])
            );
        end
    endgenerate

    assign own_any = sys_hit || (|pg_hit);
    assign acc_any = sfr_rd || sfr_wr;
    // Owned registers never leak to the peripherals as a second access
    assign take_ext = acc_any && in_sfr && !own_any;

    // Read data of the registers held here
    always_comb
    begin
        rd_next = `SAE_ZERO8;
        if (sys_hit)
            rd_next = system_control_zero_reg;
        for (int i = 0; i < NMOD; i++)
        begin
            if (pg_hit[i])
                rd_next = 8'(pages[i]);
        end
    end

    // Lowest module wins if windows ever overlap
    always_comb
    begin
        mod_next  = sae_pkg::SAE_MOD_NONE;
        page_next = PW'(`SAE_PAGE_RST);
        for (int i = NMOD - 1; i >= 0; i--)
        begin
            if (win_hit[i])
            begin
                mod_next  = sae_pkg::sae_mod_t'(i);
                page_next = pages[i];
            end
        end
    end

    // Owned-register hit, one cycle after the access
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            own_hit_reg <= 1'b0;
        else if (ce)
            own_hit_reg <= acc_any && own_any;
    end

    // Read data holds until the next read, writes leave it alone
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            rdata_reg <= `SAE_ZERO8;
        else if (ce && sfr_rd)
            rdata_reg <= rd_next;
    end

    // Decoded access strobe, one cycle after the CPU request
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            dvalid_reg <= 1'b0;
        else if (ce)
            dvalid_reg <= take_ext;
    end

    // Write side of the decoded access
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dwrite_reg <= 1'b0;
            dwdata_reg <= `SAE_ZERO8;
        end
        else if (ce && take_ext)
        begin
            dwrite_reg <= sfr_wr;
            dwdata_reg <= sfr_wdata;
        end
    end

    // Target of the decoded access; fields hold between accesses
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dmapped_reg <= 1'b0;
            dmod_reg    <= sae_pkg::SAE_MOD_NONE;
            dpage_reg   <= PW'(`SAE_PAGE_RST);
            doff_reg    <= `SAE_OFF_RST;
        end
        else if (ce && take_ext)
        begin
            dmapped_reg <= mapped;
            dmod_reg    <= mod_next;
            dpage_reg   <= page_next;
            doff_reg    <= sfr_addr[`SAE_OFF_MSB:0];
        end
    end

    // Outputs come straight from flip-flops
    assign sfr_rdata      = rdata_reg;
    assign own_hit        = own_hit_reg;
    assign map_select_bit = mapped;
    assign dec_valid      = dvalid_reg;
    assign dec_write      = dwrite_reg;
    assign dec_mapped     = dmapped_reg;
    assign dec_mod        = dmod_reg;
    assign dec_page       = dpage_reg;
    assign dec_offset     = doff_reg;
    assign dec_wdata      = dwdata_reg;

endmodule // sae_top

// *** sim/sae_top_sva.sv ***
`timescale 1ns/10ps
`include "sae_map.svh"
module sae_top_sva #(
    parameter int PW = 3
) (
    input wire logic              ref_clk,
    input wire logic              resetn,
    input wire logic              ce,
    input wire logic [7:0]        sfr_addr,
    input wire logic              sfr_wr,
    input wire logic              sfr_rd,
    input wire logic [7:0]        sfr_wdata,
    input wire logic              own_hit,
    input wire logic              map_select_bit,
    input wire logic              dec_valid,
    input wire logic              dec_mapped,
    input wire sae_pkg::sae_mod_t dec_mod,
    input wire logic [PW-1:0]     dec_page,
    input wire logic [6:0]        dec_offset
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    logic acc;
    logic sys_wr;
    assign acc = ce && (sfr_rd || sfr_wr);
    assign sys_wr = ce && sfr_wr && sfr_addr == `SAE_SYSTEM_CONTROL_ZERO_ADDR;
    low_addr_a: assert property (
        acc && !sfr_addr[7] |=> !dec_valid && !own_hit)
        else $error("access below range answered");
    map_write_a: assert property (
        sys_wr |=> map_select_bit == $past(sfr_wdata[0]))
        else $error("map bit not taken from write");
    map_hold_a: assert property (
        !sys_wr |=> $stable(map_select_bit))
        else $error("map bit changed without write");
    mapped_route_a: assert property (
        acc && sfr_addr[7] && sfr_addr != `SAE_SYSTEM_CONTROL_ZERO_ADDR
        && map_select_bit
        |=> dec_valid && dec_mapped && dec_mod == sae_pkg::SAE_MOD_NONE)
        else $error("mapped access misrouted");
    std_route_a: assert property (
        acc && sfr_addr == 8'h80 && !map_select_bit
        |=> dec_valid && !dec_mapped && dec_offset == 7'h00)
        else $error("standard access misrouted");
    adc_win_a: assert property (
        acc && sfr_addr == `SAE_ADC_LO && !map_select_bit
        |=> dec_mod == sae_pkg::SAE_MOD_ADC)
        else $error("paged window owner wrong");
    page_own_a: assert property (
        ce && sfr_wr && sfr_addr == `SAE_ADC_PADDR && !map_select_bit
        |=> own_hit && !dec_valid)
        else $error("page write not taken here");
    page_use_a: assert property (
        ce && sfr_wr && sfr_addr == `SAE_ADC_PADDR && !map_select_bit
        && !sfr_wdata[7] ##1 !sfr_wr ##1 ce && sfr_rd && !sfr_wr
        && !map_select_bit && sfr_addr == `SAE_ADC_LO
        |=> dec_page == $past(sfr_wdata[2:0], 3))
        else $error("paged access used wrong page");
    cover property (acc && map_select_bit);
    cover property (own_hit);
    cover property (dec_valid && dec_mod == sae_pkg::SAE_MOD_SCU);
    cover property (ce && sfr_wr && sfr_addr == `SAE_ADC_PADDR
        && sfr_wdata[7:6] == 2'h3);
endmodule // sae_top_sva

bind sae_top sae_top_sva #(.PW(PW)) chk (.ref_clk(ref_clk), .resetn(resetn),
    .ce(ce), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .own_hit(own_hit), .map_select_bit(map_select_bit),
    .dec_valid(dec_valid), .dec_mapped(dec_mapped), .dec_mod(dec_mod),
    .dec_page(dec_page), .dec_offset(dec_offset));

// *** sim/sae_cpu_model.sv ***
`timescale 1ns/10ps
module sae_cpu_model (
    // Clock
    input  wire logic ref_clk,
    // Register access
    output logic [7:0] sfr_addr,
    output logic       sfr_wr,
    output logic       sfr_rd,
    output logic [7:0] sfr_wdata
);
    initial
    begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
    end
    // One byte access, held up to its taking edge
    task automatic acc(input logic [7:0] a, input logic w,
                       input logic [7:0] d);
        @(posedge ref_clk);
        sfr_addr <= a;
        sfr_wr <= w;
        sfr_rd <= !w;
        sfr_wdata <= d;
        @(posedge ref_clk);
        sfr_wr <= 1'b0;
        sfr_rd <= 1'b0;
        // Idle bus must not keep showing the last value
        sfr_addr <= ~a;
        sfr_wdata <= ~d;
    endtask
endmodule // sae_cpu_model

// *** sim/tb.sv ***
`timescale 1ns/10ps
module tb;
    logic              ref_clk, resetn, ce, sfr_wr, sfr_rd, own_hit;
    logic              map_select_bit, dec_valid, dec_write, dec_mapped;
    logic [7:0]        sfr_addr, sfr_wdata, sfr_rdata, dec_wdata;
    sae_pkg::sae_mod_t dec_mod;
    logic [2:0]        dec_page;
    logic [6:0]        dec_offset;
    int                failures, comparisons, cycles;
    localparam logic [7:0] PA[4] = '{8'hB2, 8'hD1, 8'hA3, 8'hBF};
    localparam logic [7:0] LO[4] = '{8'hB0, 8'hCA, 8'h9A, 8'hB4};

    sae_cpu_model cpu (.ref_clk(ref_clk), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata));
    sae_top dut (.ref_clk(ref_clk), .resetn(resetn), .ce(ce),
        .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .own_hit(own_hit),
        .map_select_bit(map_select_bit), .dec_valid(dec_valid),
        .dec_write(dec_write), .dec_mapped(dec_mapped), .dec_mod(dec_mod),
        .dec_page(dec_page), .dec_offset(dec_offset), .dec_wdata(dec_wdata));

    task final_report;
        if (failures == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", n, e, g);
            failures++;
        end
    endtask
    // Settle after the answering edge before sampling
    task go(input logic [7:0] a, input logic w, input logic [7:0] d);
        cpu.acc(a, w, d);
        #1;
    endtask
    task t_low;
        go(8'h7F, 1'b0, 8'h00);
        chk("dec_valid", 8'h00, 8'(dec_valid));
        chk("own_hit", 8'h00, 8'(own_hit));
        go(8'hFF, 1'b0, 8'h00);
        chk("dec_offset", 8'h7F, 8'(dec_offset));
        go(8'h80, 1'b1, 8'h5A);
        chk("dec_valid", 8'h01, 8'(dec_valid));
        chk("dec_write", 8'h01, 8'(dec_write));
        chk("dec_wdata", 8'h5A, dec_wdata);
        chk("dec_offset", 8'h00, 8'(dec_offset));
    endtask
    task t_map;
        go(8'h8F, 1'b1, 8'h01);
        chk("map", 8'h01, 8'(map_select_bit));
        go(8'hCA, 1'b0, 8'h00);
        chk("dec_mapped", 8'h01, 8'(dec_mapped));
        chk("dec_mod", 8'h04, 8'(dec_mod));
        repeat (20) @(posedge ref_clk);
        #1;
        chk("map", 8'h01, 8'(map_select_bit));
        go(8'h8F, 1'b0, 8'h00);
        chk("sfr_rdata", 8'h01, sfr_rdata);
        chk("own_hit", 8'h01, 8'(own_hit));
        go(8'h8F, 1'b1, 8'h00);
        go(8'h8F, 1'b0, 8'h00);
        chk("sfr_rdata", 8'h00, sfr_rdata);
        go(8'hCA, 1'b0, 8'h00);
        chk("dec_mapped", 8'h00, 8'(dec_mapped));
        chk("dec_mod", 8'h01, 8'(dec_mod));
        chk("dec_offset", 8'h4A, 8'(dec_offset));
        chk("dec_page", 8'h00, 8'(dec_page));
    endtask
    task t_page;
        for (int i = 0; i < 4; i++)
            go(PA[i], 1'b1, 8'(i + 1));
        for (int i = 0; i < 4; i++)
        begin
            go(LO[i], 1'b0, 8'h00);
            chk("dec_mod", 8'(i), 8'(dec_mod));
            chk("dec_page", 8'(i + 1), 8'(dec_page));
        end
    endtask
    task t_save;
        go(8'hD1, 1'b1, 8'h05);
        chk("own_hit", 8'h01, 8'(own_hit));
        go(8'hCA, 1'b0, 8'h00);
        chk("dec_page", 8'h05, 8'(dec_page));
        go(8'hD1, 1'b1, 8'h92);
        go(8'hCA, 1'b0, 8'h00);
        chk("dec_page", 8'h02, 8'(dec_page));
        go(8'hD1, 1'b1, 8'hD7);
        go(8'hCA, 1'b0, 8'h00);
        chk("dec_page", 8'h05, 8'(dec_page));
        go(8'hD1, 1'b0, 8'h00);
        chk("sfr_rdata", 8'h05, sfr_rdata);
    endtask
    task t_hold;
        @(posedge ref_clk);
        ce <= 1'b0;
        go(8'h8F, 1'b1, 8'h01);
        chk("map", 8'h00, 8'(map_select_bit));
        @(posedge ref_clk);
        ce <= 1'b1;
    endtask

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            final_report();
        end
    end
    initial
    begin
        resetn = 1'b0;
        ce = 1'b1;
        failures = 0;
        comparisons = 0;
        cycles = 0;
        repeat (2) @(posedge ref_clk);
        resetn <= 1'b1;
        #1;
        chk("map", 8'h00, 8'(map_select_bit));
        chk("dec_mod", 8'h04, 8'(dec_mod));
        t_low();
        t_map();
        t_page();
        t_save();
        t_hold();
        final_report();
    end
endmodule // tb
